// ---- logic/pir_indicator_regs.sv ----
// indicator and protection register bank with link-side request port
`timescale 1ns/1ns

// Function
// - bit 4 enables over-voltage guard
// - bit 3 enables under-voltage guard
// - bit 0 selects packet check policy
// - comm failure pulls alert unless routed off
// - crc failure pulls alert unless routed off
// - comm failure pulls power good unless off
// - crc failure pulls power good unless off
// - alert release delay from bits 3:2
// - power good release delay from bits 1:0
// - bit 1 masks this channel's good input
// - bit 0 selects tight good window
// - conduction mode resets to 01
// - current limit scale 100/75/50 percent
// - answer all accesses, hit only at stored 7-bit address
// - config code read returns programmed value
// - boot load crc error sets bit 5
// - boot load indicator error sets bit 4
// - failed store sets bit 3
module pir_indicator_regs
  import pir_pkg::*;
#(
  parameter int REL_2MS_CYC = CYC_2MS,
  parameter int REL_5MS_CYC = CYC_5MS,
  parameter int REL_10MS_CYC = CYC_10MS,
  parameter int CNT_W = 24
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic link_clk_in,
  input wire logic link_valid_in,
  input wire pir_req_s link_req_in,
  input wire logic link_comm_fail_in,
  input wire logic link_crc_fail_in,
  input wire logic clear_faults_in,
  input wire logic alert_src_in,
  input wire logic good_raw_in,
  input wire logic otp_load_done_in,
  input wire logic otp_crc_err_in,
  input wire logic otp_ind_err_in,
  input wire logic otp_store_fail_in,
  input wire logic [7:0] config_code_in,
  output logic link_ready_out,
  output logic link_done_out,
  output pir_rsp_s link_rsp_out,
  output logic overvoltage_guard_on_out,
  output logic undervoltage_guard_on_out,
  output logic packet_check_policy_out,
  output logic good_channel_mask_out,
  output logic good_window_select_out,
  output logic forced_continuous_mode_out,
  output logic [1:0] current_limit_scale_out,
  output logic alert_n_out,
  output logic power_good_out,
  output logic comm_fail_flag_out,
  output logic crc_fail_flag_out
);

  localparam logic [1:0] LVL_RST = 2'b01;

  // link domain state
  logic lrst_s1;
  logic lrst_s2;
  pir_req_s req_hold;
  logic req_tgl;
  logic comm_tgl;
  logic crc_tgl;
  logic ack_s1;
  logic ack_s2;
  logic ack_s3;

  // system domain state
  logic [2:0] req_sync;
  logic [2:0] comm_sync;
  logic [2:0] crc_sync;
  logic ack_tgl;
  pir_rsp_s rsp_hold;
  logic [7:0] prot_reg;
  logic [7:0] alrt_reg;
  logic [7:0] good_reg;
  logic [7:0] dly_reg;
  logic [7:0] win_reg;
  logic [7:0] cond_reg;
  logic [7:0] ilim_reg;
  logic [7:0] addr_reg;
  logic [7:0] code_reg;
  logic [7:0] otp_reg;
  logic [1:0] ilim_eff;
  logic comm_flag;
  logic crc_flag;
  logic [7:0] rd_data;
  logic acc_go;
  logic acc_hit;
  logic acc_wr;
  logic ev_comm;
  logic ev_crc;
  logic [1:0] ind_pull;
  logic [1:0] ind_lvl;
  logic [1:0][1:0] ind_sel;

  // reset brought into the link domain
  always_ff @(posedge link_clk_in) begin
    lrst_s1 <= sys_rst_in;
    lrst_s2 <= lrst_s1;
  end

  // request capture, one outstanding at a time
  always_ff @(posedge link_clk_in) begin
    if (lrst_s2) begin
      req_hold <= '0;
      req_tgl <= 1'b0;
      link_ready_out <= 1'b0;
    end else if (link_valid_in && link_ready_out) begin
      req_hold <= link_req_in;
      req_tgl <= ~req_tgl;
      link_ready_out <= 1'b0;
    end else if (ack_s2 ^ ack_s3) begin
      link_ready_out <= 1'b1;
    end else if (!link_ready_out && (req_tgl == ack_s3)) begin
      link_ready_out <= 1'b1;
    end
  end

  // answer return from the system domain
  always_ff @(posedge link_clk_in) begin
    if (lrst_s2) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      link_done_out <= 1'b0;
      link_rsp_out <= '0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      link_done_out <= ack_s2 ^ ack_s3;
      if (ack_s2 ^ ack_s3) begin
        link_rsp_out <= rsp_hold;
      end
    end
  end

  // bus failure events toggled across
  always_ff @(posedge link_clk_in) begin
    if (lrst_s2) begin
      comm_tgl <= 1'b0;
      crc_tgl <= 1'b0;
    end else begin
      comm_tgl <= comm_tgl ^ link_comm_fail_in;
      crc_tgl <= crc_tgl ^ link_crc_fail_in;
    end
  end

  // toggle synchronisers into the system domain
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      req_sync <= '0;
      comm_sync <= '0;
      crc_sync <= '0;
    end else begin
      req_sync <= {req_sync[1:0], req_tgl};
      comm_sync <= {comm_sync[1:0], comm_tgl};
      crc_sync <= {crc_sync[1:0], crc_tgl};
    end
  end

  assign acc_go = req_sync[2] ^ req_sync[1];
  assign ev_comm = comm_sync[2] ^ comm_sync[1];
  assign ev_crc = crc_sync[2] ^ crc_sync[1];
  assign acc_hit = req_hold.target == addr_reg[6:0];
  assign acc_wr = acc_go && req_hold.wr && acc_hit;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      prot_reg <= RST_PROT;
      alrt_reg <= RST_ALRT;
      good_reg <= RST_GOOD;
      dly_reg <= RST_DLY;
      win_reg <= RST_WIN;
      cond_reg <= RST_COND;
      ilim_reg <= RST_ILIM;
      addr_reg <= RST_ADDR;
    end else if (acc_wr) begin
      if (req_hold.code == OFS_PROT) begin
        prot_reg <= req_hold.data & MSK_PROT;
      end else if (req_hold.code == OFS_ALRT) begin
        alrt_reg <= req_hold.data & MSK_ALRT;
      end else if (req_hold.code == OFS_GOOD) begin
        good_reg <= req_hold.data & MSK_GOOD;
      end else if (req_hold.code == OFS_DLY) begin
        dly_reg <= req_hold.data & MSK_DLY;
      end else if (req_hold.code == OFS_WIN) begin
        win_reg <= req_hold.data & MSK_WIN;
      end else if (req_hold.code == OFS_COND) begin
        cond_reg <= req_hold.data & MSK_COND;
      end else if (req_hold.code == OFS_ILIM) begin
        ilim_reg <= req_hold.data & MSK_ILIM;
      end else if (req_hold.code == OFS_ADDR) begin
        addr_reg <= req_hold.data & MSK_ADDR;
      end
    end
  end

  // read mux, unmapped codes read zero
  always_comb begin
    if (req_hold.code == OFS_PROT) begin
      rd_data = prot_reg;
    end else if (req_hold.code == OFS_ALRT) begin
      rd_data = alrt_reg;
    end else if (req_hold.code == OFS_GOOD) begin
      rd_data = good_reg;
    end else if (req_hold.code == OFS_DLY) begin
      rd_data = dly_reg;
    end else if (req_hold.code == OFS_WIN) begin
      rd_data = win_reg;
    end else if (req_hold.code == OFS_COND) begin
      rd_data = cond_reg;
    end else if (req_hold.code == OFS_ILIM) begin
      rd_data = ilim_reg;
    end else if (req_hold.code == OFS_ADDR) begin
      rd_data = addr_reg;
    end else if (req_hold.code == OFS_CODE) begin
      rd_data = code_reg;
    end else if (req_hold.code == OFS_OTP) begin
      rd_data = otp_reg;
    end else begin
      rd_data = 8'h00;
    end
  end

  // answer capture and acknowledge toggle
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rsp_hold <= '0;
      ack_tgl <= 1'b0;
    end else if (acc_go) begin
      rsp_hold.hit <= acc_hit;
      rsp_hold.data <= (acc_hit && !req_hold.wr) ? rd_data : 8'h00;
      ack_tgl <= ~ack_tgl;
    end
  end

  // otp status and configuration code, written by hardware only
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      otp_reg <= RST_OTP;
      code_reg <= RST_CODE;
    end else begin
      if (otp_load_done_in) begin
        code_reg <= config_code_in;
      end
      if (otp_load_done_in && otp_crc_err_in) begin
        otp_reg[B_CRC_ERR] <= 1'b1;
      end
      if (otp_load_done_in && otp_ind_err_in) begin
        otp_reg[B_IND_ERR] <= 1'b1;
      end
      if (otp_store_fail_in) begin
        otp_reg[B_STORE_ERR] <= 1'b1;
      end
    end
  end

  // sticky bus failure flags, set wins over clear
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      comm_flag <= 1'b0;
      crc_flag <= 1'b0;
    end else begin
      comm_flag <= ev_comm | (comm_flag & ~clear_faults_in);
      crc_flag <= ev_crc | (crc_flag & ~clear_faults_in);
    end
  end

  // current limit scale, reserved code as full
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ilim_eff <= PIR_ILIM_100;
    end else if (ilim_reg[1:0] == PIR_ILIM_RSV) begin
      ilim_eff <= PIR_ILIM_100;
    end else begin
      ilim_eff <= ilim_reg[1:0];
    end
  end

  assign overvoltage_guard_on_out = prot_reg[B_OVP];
  assign undervoltage_guard_on_out = prot_reg[B_UVP];
  assign packet_check_policy_out = prot_reg[B_PEC];
  assign good_channel_mask_out = win_reg[B_MASK];
  assign good_window_select_out = win_reg[B_WIN];
  assign forced_continuous_mode_out = cond_reg[B_FORCED_CONTINUOUS_MODE];
  assign current_limit_scale_out = ilim_eff;
  assign comm_fail_flag_out = comm_flag;
  assign crc_fail_flag_out = crc_flag;

  assign ind_pull[0] = alert_src_in
    | (comm_flag & ~alrt_reg[B_COMM_MAP])
    | (crc_flag & ~alrt_reg[B_CRC_MAP]);
  assign ind_pull[1] = (~good_raw_in & ~win_reg[B_MASK])
    | (comm_flag & ~good_reg[B_COMM_MAP])
    | (crc_flag & ~good_reg[B_CRC_MAP]);
  assign ind_sel[0] = dly_reg[B_ALERT_DLY+1:B_ALERT_DLY];
  assign ind_sel[1] = dly_reg[B_GOOD_DLY+1:B_GOOD_DLY];

  // release delay per indicator, index 0 alert, 1 power good
  for (genvar gi = 0; gi < 2; gi++) begin : g_ind
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lim;
    logic lvl;

    always_comb begin
      case (pir_delay_e'(ind_sel[gi]))
        PIR_DLY_2MS: lim = CNT_W'(REL_2MS_CYC - 1);
        PIR_DLY_5MS: lim = CNT_W'(REL_5MS_CYC - 1);
        PIR_DLY_10MS: lim = CNT_W'(REL_10MS_CYC - 1);
        default: lim = '0;
      endcase
    end

    always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
        lvl <= LVL_RST[gi];
        cnt <= '0;
      end else if (ind_pull[gi]) begin
        lvl <= 1'b0;
        cnt <= '0;
      end else if (!lvl) begin
        if (cnt >= lim) begin
          lvl <= 1'b1;
          cnt <= '0;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end

    assign ind_lvl[gi] = lvl;
  end

  assign alert_n_out = ind_lvl[0];
  assign power_good_out = ind_lvl[1];

  a_ovp_write: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_wr && req_hold.code == OFS_PROT
    |=> overvoltage_guard_on_out == $past(req_hold.data[B_OVP]))
    else $error("over-voltage enable does not follow write");

  a_uvp_write: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_wr && req_hold.code == OFS_PROT
    |=> undervoltage_guard_on_out == $past(req_hold.data[B_UVP]))
    else $error("under-voltage enable does not follow write");

  a_comm_alert: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    comm_flag && !alrt_reg[B_COMM_MAP] |=> !alert_n_out)
    else $error("comm failure did not pull alert");

  a_crc_good: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    crc_flag && !good_reg[B_CRC_MAP] |=> !power_good_out)
    else $error("crc failure did not pull power good");

  a_alert_immediate: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !alert_n_out && !ind_pull[0] && ind_sel[0] == PIR_DLY_NONE
    |=> alert_n_out)
    else $error("immediate alert release late");

  a_good_hold: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    $fell(power_good_out) && ind_sel[1] != PIR_DLY_NONE
    && REL_2MS_CYC > 2 |=> !power_good_out [*2])
    else $error("power good released too early");

  a_light_reset: assert property (
    @(posedge sys_clk_in)
    $past(sys_rst_in) && !sys_rst_in |-> cond_reg == RST_COND)
    else $error("conduction mode reset value wrong");

  a_ilim_map: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    ilim_reg[1:0] == PIR_ILIM_RSV |=> current_limit_scale_out == 2'b00)
    else $error("reserved limit code not full scale");

  a_addr_miss: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_go && !acc_hit |=> $stable(prot_reg) && $stable(addr_reg)
    && !rsp_hold.hit)
    else $error("access at foreign address took effect");

  a_code_read: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_go && acc_hit && !req_hold.wr && req_hold.code == OFS_CODE
    |=> rsp_hold.data == $past(code_reg))
    else $error("configuration code read wrong");

  a_otp_crc: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    otp_load_done_in && otp_crc_err_in |=> otp_reg[B_CRC_ERR])
    else $error("boot crc error not flagged");

  a_store_fail: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    otp_store_fail_in |=> otp_reg[B_STORE_ERR] [*2])
    else $error("store failure not held");

  a_rsvd_zero: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (prot_reg & ~MSK_PROT) == 8'h00 && (dly_reg & ~MSK_DLY) == 8'h00)
    else $error("reserved bits not zero");

  a_link_done: assert property (
    @(posedge link_clk_in) disable iff (lrst_s2)
    link_done_out |-> link_ready_out)
    else $error("answer given while request still open");

  c_write_hit: cover property (
    @(posedge sys_clk_in) disable iff (sys_rst_in) acc_wr);
  c_read_code: cover property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_go && !req_hold.wr && req_hold.code == OFS_CODE);
  c_alert_release: cover property (
    @(posedge sys_clk_in) disable iff (sys_rst_in) $rose(alert_n_out));
  c_addr_miss: cover property (
    @(posedge sys_clk_in) disable iff (sys_rst_in) acc_go && !acc_hit);

endmodule // pir_indicator_regs

// ---- logic/pir_pkg.sv ----
// package: offsets, field positions, reset values and timing of the bank
package pir_pkg;

  // command codes of the register bank
  localparam logic [7:0] OFS_PROT = 8'hc2;
  localparam logic [7:0] OFS_ALRT = 8'hc4;
  localparam logic [7:0] OFS_GOOD = 8'hc6;
  localparam logic [7:0] OFS_DLY = 8'hc8;
  localparam logic [7:0] OFS_WIN = 8'hca;
  localparam logic [7:0] OFS_COND = 8'hcc;
  localparam logic [7:0] OFS_ILIM = 8'hce;
  localparam logic [7:0] OFS_ADDR = 8'hd5;
  localparam logic [7:0] OFS_CODE = 8'hd6;
  localparam logic [7:0] OFS_OTP = 8'hdb;

  // writable bits of each register; all other bits read as zero
  localparam logic [7:0] MSK_PROT = 8'h19;
  localparam logic [7:0] MSK_ALRT = 8'h0c;
  localparam logic [7:0] MSK_GOOD = 8'h0c;
  localparam logic [7:0] MSK_DLY = 8'h0f;
  localparam logic [7:0] MSK_WIN = 8'h03;
  localparam logic [7:0] MSK_COND = 8'h01;
  localparam logic [7:0] MSK_ILIM = 8'h03;
  localparam logic [7:0] MSK_ADDR = 8'h7f;

  // reset values
  localparam logic [7:0] RST_PROT = 8'h00;
  localparam logic [7:0] RST_ALRT = 8'h00;
  localparam logic [7:0] RST_GOOD = 8'h00;
  localparam logic [7:0] RST_DLY = 8'h05;
  localparam logic [7:0] RST_WIN = 8'h00;
  localparam logic [7:0] RST_COND = 8'h01;
  localparam logic [7:0] RST_ILIM = 8'h00;
  // default target address, value arbitrary
  localparam logic [7:0] RST_ADDR = 8'h20;
  localparam logic [7:0] RST_CODE = 8'h00;
  localparam logic [7:0] RST_OTP = 8'h00;

  // field positions
  localparam int B_OVP = 4;
  localparam int B_UVP = 3;
  localparam int B_PEC = 0;
  localparam int B_COMM_MAP = 3;
  localparam int B_CRC_MAP = 2;
  localparam int B_ALERT_DLY = 2;
  localparam int B_GOOD_DLY = 0;
  localparam int B_MASK = 1;
  localparam int B_WIN = 0;
  localparam int B_FORCED_CONTINUOUS_MODE = 0;
  localparam int B_CRC_ERR = 5;
  localparam int B_IND_ERR = 4;
  localparam int B_STORE_ERR = 3;

  // timing
  localparam int CLK_MHZ = 125;
  localparam int T_2MS_US = 2000;
  localparam int T_5MS_US = 5000;
  localparam int T_10MS_US = 10000;
  localparam int CYC_2MS = T_2MS_US * CLK_MHZ;
  localparam int CYC_5MS = T_5MS_US * CLK_MHZ;
  localparam int CYC_10MS = T_10MS_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PIR_DLY_NONE = 2'b00,
    PIR_DLY_2MS = 2'b01,
    PIR_DLY_5MS = 2'b10,
    PIR_DLY_10MS = 2'b11
  } pir_delay_e;

  typedef enum logic [1:0] {
    PIR_ILIM_100 = 2'b00,
    PIR_ILIM_75 = 2'b01,
    PIR_ILIM_50 = 2'b10,
    PIR_ILIM_RSV = 2'b11
  } pir_ilim_e;

  typedef struct packed {
    logic wr;
    logic [6:0] target;
    logic [7:0] code;
    logic [7:0] data;
  } pir_req_s;

  typedef struct packed {
    logic hit;
    logic [7:0] data;
  } pir_rsp_s;

endpackage

// ---- testbench/pir_host_model.sv ----
// link-side host model issuing single-byte register accesses
`timescale 1ns/1ns
module pir_host_model
  import pir_pkg::*;
(
  input wire logic link_clk_in,
  input wire logic link_ready_in,
  input wire logic link_done_in,
  input wire pir_rsp_s link_rsp_in,
  output logic link_valid_out,
  output pir_req_s link_req_out,
  output logic comm_fail_out,
  output logic crc_fail_out
);
  initial begin
    link_valid_out = 1'h0;
    link_req_out = '0;
    comm_fail_out = 1'h0;
    crc_fail_out = 1'h0;
  end

  task automatic access(input logic wr, input logic [6:0] tgt,
      input logic [7:0] code, input logic [7:0] data, output pir_rsp_s rsp);
    int n;
    n = 0;
    // wait for ready, sampled after the edge has settled
    do begin
      @(posedge link_clk_in);
      #1;
    end while (link_ready_in !== 1'h1 && ++n < 100);
    @(posedge link_clk_in);
    link_valid_out <= 1'h1;
    link_req_out <= {wr, tgt, code, data};
    // ready stands high here, so this edge takes the request
    @(posedge link_clk_in);
    link_valid_out <= 1'h0;
    // released request shows inverted bits
    link_req_out <= ~{wr, tgt, code, data};
    n = 0;
    do begin
      @(posedge link_clk_in);
      #1;
    end while (link_done_in !== 1'h1 && ++n < 100);
    rsp = link_rsp_in;
  endtask

  task automatic fail_pulse(input logic crc);
    @(posedge link_clk_in);
    comm_fail_out <= !crc;
    crc_fail_out <= crc;
    @(posedge link_clk_in);
    comm_fail_out <= 1'h0;
    crc_fail_out <= 1'h0;
  endtask
endmodule // pir_host_model

// ---- testbench/pir_indicator_regs_test.sv ----
// self-checking bench for the indicator and protection register bank
`timescale 1ns/1ns
module pir_indicator_regs_test;
  import pir_pkg::*;
  localparam int C2 = 20;
  localparam int C5 = 50;
  localparam int C10 = 100;
  logic sys_clk_in = 1'h0;
  logic link_clk = 1'h0;
  logic sys_rst_in = 1'h1;
  logic clear_faults = 1'h0, alert_src = 1'h0, good_raw = 1'h0;
  logic otp_done = 1'h0, otp_crc = 1'h0, otp_ind = 1'h0, otp_store = 1'h0;
  logic [7:0] cfg_code = 8'h00;
  logic link_valid, comm_fail, crc_fail, ready, done, overvoltage_guard, undervoltage_guard, pec;
  logic gmask, gwin, forced_continuous_mode, alert_n, pgood, cflag, rflag;
  logic [1:0] ilim;
  pir_req_s link_req;
  pir_rsp_s rsp;
  logic [6:0] tgt = 7'h20;
  int fails = 0;
  int checks = 0;
  logic [7:0] ofs [10] = '{OFS_PROT, OFS_ALRT, OFS_GOOD, OFS_DLY, OFS_WIN,
      OFS_COND, OFS_ILIM, OFS_ADDR, OFS_CODE, OFS_OTP};
  logic [7:0] rstv [10] = '{RST_PROT, RST_ALRT, RST_GOOD, RST_DLY, RST_WIN,
      RST_COND, RST_ILIM, RST_ADDR, RST_CODE, RST_OTP};
  logic [7:0] mskv [7] = '{MSK_PROT, MSK_ALRT, MSK_GOOD, MSK_DLY, MSK_WIN,
      MSK_COND, MSK_ILIM};

  always #4 sys_clk_in = ~sys_clk_in;
  initial begin
    #3;
    forever #16 link_clk = ~link_clk;
  end

  pir_indicator_regs #(.REL_2MS_CYC(C2), .REL_5MS_CYC(C5),
      .REL_10MS_CYC(C10)) DUT (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .link_clk_in(link_clk), .link_valid_in(link_valid),
    .link_req_in(link_req), .link_comm_fail_in(comm_fail),
    .link_crc_fail_in(crc_fail), .clear_faults_in(clear_faults),
    .alert_src_in(alert_src), .good_raw_in(good_raw),
    .otp_load_done_in(otp_done), .otp_crc_err_in(otp_crc),
    .otp_ind_err_in(otp_ind), .otp_store_fail_in(otp_store),
    .config_code_in(cfg_code), .link_ready_out(ready),
    .link_done_out(done), .link_rsp_out(rsp),
    .overvoltage_guard_on_out(overvoltage_guard), .undervoltage_guard_on_out(undervoltage_guard),
    .packet_check_policy_out(pec), .good_channel_mask_out(gmask),
    .good_window_select_out(gwin), .forced_continuous_mode_out(forced_continuous_mode),
    .current_limit_scale_out(ilim), .alert_n_out(alert_n),
    .power_good_out(pgood), .comm_fail_flag_out(cflag),
    .crc_fail_flag_out(rflag));

  pir_host_model host (
    .link_clk_in(link_clk), .link_ready_in(ready), .link_done_in(done),
    .link_rsp_in(rsp), .link_valid_out(link_valid),
    .link_req_out(link_req), .comm_fail_out(comm_fail),
    .crc_fail_out(crc_fail));

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h0, e}, {7'h0, g});
  endtask

  task automatic chkn(input string nm, input int lo, input int g);
    checks++;
    if (g < lo || g > lo + 2) begin
      fails++;
      $display("MISMATCH %s expected %0d seen %0d", nm, lo, g);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] code, input logic [7:0] d);
    pir_rsp_s r;
    host.access(1'h1, tgt, code, d, r);
    chk1("write hit", 1'h1, r.hit);
  endtask

  task automatic rdchk(input logic [7:0] code, input logic [7:0] e);
    pir_rsp_s r;
    host.access(1'h0, tgt, code, 8'h00, r);
    chk8($sformatf("reg %h", code), e, r.data);
  endtask

  task automatic sys_wait(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  task automatic outs(input logic v);
    sys_wait(4);
    chk8("config outs", {2'h0, {6{v}}}, {2'h0, overvoltage_guard, undervoltage_guard, pec, gmask, gwin, forced_continuous_mode});
  endtask

  task automatic t_regs();
    for (int i = 0; i < 10; i++) rdchk(ofs[i], rstv[i]);
    for (int i = 0; i < 7; i++) begin
      wr(ofs[i], 8'hff);
      rdchk(ofs[i], mskv[i]);
    end
    outs(1'h1);
    for (int i = 0; i < 7; i++) begin
      wr(ofs[i], 8'h00);
      rdchk(ofs[i], 8'h00);
    end
    outs(1'h0);
    for (int i = 0; i < 7; i++) wr(ofs[i], rstv[i]);
  endtask

  task automatic t_ilim();
    for (int c = 0; c < 4; c++) begin
      wr(OFS_ILIM, 8'(c));
      sys_wait(4);
      chk8("ilim out", (c == 3) ? 8'h00 : 8'(c), {6'h0, ilim});
      rdchk(OFS_ILIM, 8'(c));
    end
  endtask

  task automatic t_ro();
    wr(OFS_CODE, 8'hff);
    rdchk(OFS_CODE, RST_CODE);
    wr(OFS_OTP, 8'hff);
    rdchk(OFS_OTP, RST_OTP);
    wr(8'hc3, 8'hff);
    rdchk(8'hc3, 8'h00);
    wr(OFS_COND, 8'h01);
  endtask

  task automatic t_addr();
    pir_rsp_s r;
    wr(OFS_ADDR, 8'hb5);
    tgt = 7'h35;
    rdchk(OFS_ADDR, 8'h35);
    host.access(1'h1, 7'h20, OFS_PROT, 8'hff, r);
    chk1("stale write hit", 1'h0, r.hit);
    host.access(1'h0, 7'h20, OFS_PROT, 8'h00, r);
    chk8("stale read", 8'h00, {r.hit, r.data[6:0]});
    rdchk(OFS_PROT, 8'h00);
    wr(OFS_ADDR, 8'h20);
    tgt = 7'h20;
    rdchk(OFS_ADDR, 8'h20);
  endtask

  task automatic t_otp();
    @(posedge sys_clk_in);
    cfg_code <= 8'h5a;
    otp_crc <= 1'h1;
    otp_done <= 1'h1;
    @(posedge sys_clk_in);
    otp_done <= 1'h0;
    otp_crc <= 1'h0;
    otp_store <= 1'h1;
    @(posedge sys_clk_in);
    otp_store <= 1'h0;
    rdchk(OFS_CODE, 8'h5a);
    rdchk(OFS_OTP, 8'h28);
    @(posedge sys_clk_in);
    cfg_code <= 8'h3c;
    otp_ind <= 1'h1;
    otp_done <= 1'h1;
    @(posedge sys_clk_in);
    otp_ind <= 1'h0;
    otp_done <= 1'h0;
    rdchk(OFS_OTP, 8'h38);
    rdchk(OFS_CODE, 8'h3c);
  endtask

  task automatic t_fail();
    wr(OFS_DLY, 8'h00);
    for (int k = 0; k < 4; k++) begin
      for (int e = 0; e < 2; e++) begin
        wr(OFS_ALRT, k[0] ? 8'h0c : 8'h00);
        wr(OFS_GOOD, k[1] ? 8'h0c : 8'h00);
        host.fail_pulse(e[0]);
        sys_wait(40);
        chk1("fail flag", 1'h1, e[0] ? rflag : cflag);
        chk1("alert_n", k[0], alert_n);
        chk1("power good", k[1], pgood);
        @(posedge sys_clk_in);
        clear_faults <= 1'h1;
        @(posedge sys_clk_in);
        clear_faults <= 1'h0;
        sys_wait(10);
        chk8("released", 8'h03, {6'h0, alert_n, pgood});
      end
    end
  endtask

  task automatic t_mask();
    wr(OFS_WIN, 8'h02);
    @(posedge sys_clk_in);
    good_raw <= 1'h0;
    sys_wait(5);
    chk1("masked good", 1'h1, pgood);
    wr(OFS_WIN, 8'h00);
    sys_wait(5);
    chk1("unmasked good", 1'h0, pgood);
    @(posedge sys_clk_in);
    good_raw <= 1'h1;
  endtask

  task automatic t_delay();
    int lim [4] = '{1, C2, C5, C10};
    int na, np;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_DLY, 8'(c * 5));
      @(posedge sys_clk_in);
      alert_src <= 1'h1;
      good_raw <= 1'h0;
      sys_wait(3);
      alert_src <= 1'h0;
      good_raw <= 1'h1;
      na = -1;
      np = -1;
      for (int n = 1; n <= 200 && (na < 0 || np < 0); n++) begin
        @(posedge sys_clk_in);
        #1;
        if (na < 0 && alert_n === 1'h1) na = n;
        if (np < 0 && pgood === 1'h1) np = n;
      end
      chkn("alert delay", lim[c], na);
      chkn("good delay", lim[c], np);
    end
  endtask

  initial begin
    #400_000;
    fails++;
    close_out();
  end

  initial begin
    repeat (13) @(posedge sys_clk_in);
    sys_rst_in <= 1'h0;
    good_raw <= 1'h1;
    t_regs();
    t_ilim();
    t_ro();
    t_addr();
    t_otp();
    t_fail();
    t_mask();
    t_delay();
    close_out();
  end
endmodule // pir_indicator_regs_test
